/* File: hw/hb_pkg.sv */
// Constants and field layout for the half-bridge serial command port
// Overview of operation
// - Enable high runs; low clears everything, sleeps
// - Serial port ignored unless enable high
// - Full duplex, 16-bit command and status
// - Select fall shows thermal bit until clock
// - Input shifts on rising clock, MSB first
// - Received word copied out on following falling edge
// - Status shifts out rising clock, overcurrent first
// - Select rise ends frame, output goes tristate
// - Commit last 16 bits unless frame error
// - Bit 15 clears latched faults of group
// - Bit 14 one addresses bridges 8 and 7
// - Bit 14 zero addresses bridges 6 to 1
// - Enable bit zero tristates, one drives bridge
// - Config zero low side, one high side
// - Bit 13 enables underload shutdown per group
// - Bit 0 enables global overvoltage lockout
// - Power-on reset clears all command bits
// - Frame valid only at multiples of eight clocks
// - Config status forced zero when output off
// - Power-on reset clears all status bits
package hb_pkg;
	localparam int          WORD_W        = 16;
	localparam int          BRIDGES       = 8;
	localparam int          CNT_W         = 4;
	localparam int          BYTE_MASK_W   = 3;
	localparam logic [15:0] CMD_RESET     = 16'h0000;
	localparam logic [15:0] STATUS_RESET  = 16'h0000;
	// Command word fields
	localparam int          CMD_SRR       = 15;
	localparam int          CMD_GROUP     = 14;
	localparam int          CMD_ULD       = 13;
	localparam int          CMD_OVERVOLTAGE_LOCKOUT_ENABLE      = 0;
	localparam int          HI_EN_LSB     = 7;
	localparam int          HI_CFG_LSB    = 1;
	localparam int          HI_COUNT      = 2;
	localparam int          HI_FIRST      = 6;
	localparam int          LO_EN_LSB     = 7;
	localparam int          LO_CFG_LSB    = 1;
	localparam int          LO_COUNT      = 6;
	localparam int          LO_FIRST      = 0;
	// Status word fields
	localparam int          ST_OCS        = 15;
	localparam int          ST_PSF        = 14;
	localparam int          ST_ULD        = 13;
	localparam int          ST_TW         = 0;
	// Host spacing between status reset frames
	localparam int          SRR_GAP_US    = 150;
endpackage

/* File: hw/sync_bits.sv */
// Two-flop level synchroniser for a bus of independent bits
`timescale 1ns/10ps
module sync_bits #(
	parameter int          WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Levels
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_reg <= INIT;
			q        <= INIT;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

/* File: hw/spi_link.sv */
// Serial clock domain: shifters, bit counter and data out
`timescale 1ns/10ps
module spi_link
	import hb_pkg::*;
(
	// Link pins
	input  wire logic              sclk,
	input  wire logic              reset,
	input  wire logic              chip_enable,
	input  wire logic              chip_select_n,
	input  wire logic              serial_in,
	output logic                   serial_out,
	output logic                   serial_out_oe,
	// From core, frozen while selected
	input  wire logic [WORD_W-1:0] status_word,
	input  wire logic              thermal_bit,
	// To core, stable once select is high
	output logic      [WORD_W-1:0] rx_word,
	output logic      [CNT_W-1:0]  rx_count,
	output logic                   rx_past_sixteen,
	output logic                   frame_toggle
);
	logic              started_reg;
	logic [WORD_W-1:0] shift_reg;
	logic [WORD_W-1:0] tx_reg;
	logic [CNT_W-1:0]  cnt_reg;
	logic              past_reg;
	logic              out_reg;

	// Cleared by select so a frame never depends on an edge after it ends
	always_ff @(posedge sclk or posedge chip_select_n or posedge reset) begin
		if (chip_select_n || reset)
			started_reg <= 1'b0;
		else
			started_reg <= 1'b1;
	end

	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			shift_reg <= CMD_RESET;
		end else begin
			shift_reg <= {shift_reg[WORD_W-2:0], serial_in};
		end
	end

	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			cnt_reg  <= '0;
			past_reg <= 1'b0;
		end else if (!started_reg) begin
			cnt_reg  <= CNT_W'(1);
			past_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + CNT_W'(1);
			if (cnt_reg == '1)
				past_reg <= 1'b1;
		end
	end

	// Bits beyond the status word pass through for daisy chains
	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			tx_reg  <= STATUS_RESET;
			out_reg <= 1'b0;
		end else if (!started_reg) begin
			// First input bit queues behind the status word, not lost
			tx_reg  <= {status_word[WORD_W-2:0], serial_in};
			out_reg <= status_word[WORD_W-1];
		end else begin
			tx_reg  <= {tx_reg[WORD_W-2:0], serial_in};
			out_reg <= tx_reg[WORD_W-1];
		end
	end

	always_ff @(negedge sclk or posedge reset) begin
		if (reset) begin
			rx_word         <= CMD_RESET;
			rx_count        <= '0;
			rx_past_sixteen <= 1'b0;
			frame_toggle    <= 1'b0;
		end else begin
			rx_word         <= shift_reg;
			rx_count        <= cnt_reg;
			rx_past_sixteen <= past_reg;
			if (cnt_reg == CNT_W'(1) && !past_reg)
				frame_toggle <= ~frame_toggle;
		end
	end

	// Must follow select with no clock, so this output is not a flop
	assign serial_out    = started_reg ? out_reg : thermal_bit;
	assign serial_out_oe = chip_enable & ~chip_select_n;
endmodule

/* File: hw/halfbridge_spi_command_port.sv */
// Top of the half-bridge command port: commit, faults and drive control
`timescale 1ns/10ps
module halfbridge_spi_command_port #(
	parameter int N_BRIDGES = hb_pkg::BRIDGES
) (
	// Core clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// Enable pin
	input  wire logic                 chip_enable,
	// Serial port
	input  wire logic                 sclk,
	input  wire logic                 chip_select_n,
	input  wire logic                 serial_in,
	output logic                      serial_out,
	output logic                      serial_out_oe,
	// Fault sensing, asynchronous levels
	input  wire logic [N_BRIDGES-1:0] overcurrent_fault,
	input  wire logic [N_BRIDGES-1:0] underload_fault,
	input  wire logic                 supply_fault,
	input  wire logic                 thermal_warning,
	input  wire logic                 thermal_shutdown,
	// Driver control
	output logic [N_BRIDGES-1:0]      bridge_output_state,
	output logic [N_BRIDGES-1:0]      bridge_config_state,
	output logic [N_BRIDGES-1:0]      underload_shutdown_enable,
	output logic                      overvoltage_lockout_enable,
	output logic                      sleep
);
	import hb_pkg::*;

	// Synchronised pins
	logic                 cs_n_sync;
	logic                 en_sync;
	logic                 toggle_sync;
	logic [N_BRIDGES-1:0] oc_sync;
	logic [N_BRIDGES-1:0] ul_sync;
	logic                 psf_sync;
	logic                 tw_sync;
	logic                 tsd_sync;

	// Link results
	logic [WORD_W-1:0]    rx_word;
	logic [CNT_W-1:0]     rx_count;
	logic                 rx_past_sixteen;
	logic                 frame_toggle;

	// Command and fault state
	logic [WORD_W-1:0]    command_word_group_high_reg;
	logic [WORD_W-1:0]    command_word_group_low_reg;
	logic                 channel_group_select_reg;
	logic                 cs_prev_reg;
	logic                 seen_toggle_reg;
	logic [N_BRIDGES-1:0] oc_latch_reg;
	logic [N_BRIDGES-1:0] ul_latch_reg;
	logic                 tsd_latch_reg;
	logic [WORD_W-1:0]    status_snap_reg;
	logic                 thermal_snap_reg;

	logic                 frame_end;
	logic                 frame_ok;
	logic                 commit;
	logic                 commit_high;
	logic                 status_reset_request;
	logic [N_BRIDGES-1:0] group_mask;
	logic [N_BRIDGES-1:0] bridge_output_enable;
	logic [N_BRIDGES-1:0] bridge_side_config;
	logic [N_BRIDGES-1:0] uld_enable_vec;
	logic [N_BRIDGES-1:0] bridge_on;
	logic [WORD_W-1:0]    status_word;

	// Bridges addressed by a group select value
	function automatic logic [N_BRIDGES-1:0] group_bits(input logic high);
		logic [N_BRIDGES-1:0] m;
		m = '0;
		for (int i = 0; i < N_BRIDGES; i++) begin
			if (high)
				m[i] = (i >= HI_FIRST) && (i < HI_FIRST + HI_COUNT);
			else
				m[i] = (i >= LO_FIRST) && (i < LO_FIRST + LO_COUNT);
		end
		return m;
	endfunction

	sync_bits #(
		.WIDTH (1),
		.INIT  (1'b1)
	) u_cs_sync (
		.clk   (clk),
		.reset (reset),
		.d     (chip_select_n),
		.q     (cs_n_sync)
	);

	sync_bits #(
		.WIDTH (2 * N_BRIDGES + 5),
		.INIT  ('0)
	) u_pin_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({chip_enable, frame_toggle, overcurrent_fault, underload_fault,
			supply_fault, thermal_warning, thermal_shutdown}),
		.q     ({en_sync, toggle_sync, oc_sync, ul_sync, psf_sync, tw_sync, tsd_sync})
	);

	spi_link u_link (
		.sclk            (sclk),
		.reset           (reset),
		.chip_enable     (chip_enable),
		.chip_select_n   (chip_select_n),
		.serial_in       (serial_in),
		.serial_out      (serial_out),
		.serial_out_oe   (serial_out_oe),
		.status_word     (status_snap_reg),
		.thermal_bit     (thermal_snap_reg),
		.rx_word         (rx_word),
		.rx_count        (rx_count),
		.rx_past_sixteen (rx_past_sixteen),
		.frame_toggle    (frame_toggle)
	);

	// Frame end seen after select has settled through the synchroniser
	assign frame_end   = cs_n_sync && !cs_prev_reg;
	assign frame_ok    = (toggle_sync != seen_toggle_reg) && rx_past_sixteen
		&& (rx_count[BYTE_MASK_W-1:0] == '0);
	assign commit      = frame_end && en_sync && frame_ok;
	assign commit_high = rx_word[CMD_GROUP];
	assign status_reset_request = commit && rx_word[CMD_SRR];
	assign group_mask  = group_bits(commit_high);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cs_prev_reg     <= 1'b1;
			seen_toggle_reg <= 1'b0;
		end else begin
			cs_prev_reg <= cs_n_sync;
			if (frame_end)
				seen_toggle_reg <= toggle_sync;
		end
	end

	// Enable low wipes the whole command state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			command_word_group_high_reg <= CMD_RESET;
			command_word_group_low_reg  <= CMD_RESET;
			channel_group_select_reg    <= 1'b0;
		end else if (!en_sync) begin
			command_word_group_high_reg <= CMD_RESET;
			command_word_group_low_reg  <= CMD_RESET;
			channel_group_select_reg    <= 1'b0;
		end else if (commit) begin
			channel_group_select_reg <= commit_high;
			if (commit_high)
				command_word_group_high_reg <= rx_word;
			else
				command_word_group_low_reg  <= rx_word;
		end
	end

	// Only the defined fields are decoded; other positions are dropped
	always_comb begin
		bridge_output_enable = '0;
		bridge_side_config   = '0;
		uld_enable_vec       = '0;
		for (int i = 0; i < N_BRIDGES; i++) begin
			if (i >= HI_FIRST && i < HI_FIRST + HI_COUNT) begin
				bridge_output_enable[i] =
					command_word_group_high_reg[HI_EN_LSB + i - HI_FIRST];
				bridge_side_config[i] =
					command_word_group_high_reg[HI_CFG_LSB + i - HI_FIRST];
				uld_enable_vec[i] = command_word_group_high_reg[CMD_ULD];
			end else if (i >= LO_FIRST && i < LO_FIRST + LO_COUNT) begin
				bridge_output_enable[i] =
					command_word_group_low_reg[LO_EN_LSB + i - LO_FIRST];
				bridge_side_config[i] =
					command_word_group_low_reg[LO_CFG_LSB + i - LO_FIRST];
				uld_enable_vec[i] = command_word_group_low_reg[CMD_ULD];
			end
		end
	end

	// New faults win over a status reset in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			oc_latch_reg  <= '0;
			ul_latch_reg  <= '0;
			tsd_latch_reg <= 1'b0;
		end else if (!en_sync) begin
			oc_latch_reg  <= '0;
			ul_latch_reg  <= '0;
			tsd_latch_reg <= 1'b0;
		end else begin
			oc_latch_reg <= oc_sync
				| (oc_latch_reg & ~(status_reset_request ? group_mask : '0));
			ul_latch_reg <= (ul_sync & uld_enable_vec)
				| (ul_latch_reg & ~(status_reset_request ? group_mask : '0));
			tsd_latch_reg <= tsd_sync | (tsd_latch_reg & ~status_reset_request);
		end
	end

	// Lockout only acts when the global option is set
	always_comb begin
		for (int i = 0; i < N_BRIDGES; i++) begin
			bridge_on[i] = bridge_output_enable[i] && !oc_latch_reg[i] && !ul_latch_reg[i]
				&& !tsd_latch_reg
				&& !(psf_sync && command_bits_overvoltage_lockout_enable());
		end
	end

	function automatic logic command_bits_overvoltage_lockout_enable();
		return channel_group_select_reg ? command_word_group_high_reg[CMD_OVERVOLTAGE_LOCKOUT_ENABLE]
			: command_word_group_low_reg[CMD_OVERVOLTAGE_LOCKOUT_ENABLE];
	endfunction

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bridge_output_state        <= '0;
			bridge_config_state        <= '0;
			underload_shutdown_enable  <= '0;
			overvoltage_lockout_enable <= 1'b0;
			sleep                      <= 1'b1;
		end else begin
			bridge_output_state        <= bridge_on;
			bridge_config_state        <= bridge_side_config & bridge_on;
			underload_shutdown_enable  <= uld_enable_vec;
			overvoltage_lockout_enable <= command_bits_overvoltage_lockout_enable();
			sleep                      <= !en_sync;
		end
	end

	// Status of the group chosen by the previous command
	always_comb begin
		logic [N_BRIDGES-1:0] sel;
		sel         = group_bits(channel_group_select_reg);
		status_word = STATUS_RESET;
		status_word[ST_OCS] = |(oc_latch_reg & sel);
		status_word[ST_PSF] = psf_sync;
		status_word[ST_ULD] = |(ul_latch_reg & sel);
		status_word[ST_TW]  = tw_sync;
		for (int i = 0; i < N_BRIDGES; i++) begin
			if (sel[i] && channel_group_select_reg) begin
				status_word[HI_EN_LSB + i - HI_FIRST]  = bridge_output_state[i];
				status_word[HI_CFG_LSB + i - HI_FIRST] = bridge_config_state[i];
			end else if (sel[i]) begin
				status_word[LO_EN_LSB + i - LO_FIRST]  = bridge_output_state[i];
				status_word[LO_CFG_LSB + i - LO_FIRST] = bridge_config_state[i];
			end
		end
	end

	// Snapshot frozen while selected, so the link sees a steady word
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			status_snap_reg  <= STATUS_RESET;
			thermal_snap_reg <= 1'b0;
		end else if (!en_sync) begin
			status_snap_reg  <= STATUS_RESET;
			thermal_snap_reg <= 1'b0;
		end else if (cs_n_sync && chip_select_n) begin
			status_snap_reg  <= status_word;
			thermal_snap_reg <= tsd_latch_reg;
		end
	end
endmodule

/* File: sim/hb_host.sv */
// Host serial master model for the command port
`timescale 1ns/10ps
module hb_host (
	// Serial pins
	output logic        sclk,
	output logic        chip_select_n,
	output logic        serial_in,
	input  wire logic   serial_out,
	// Captured answer
	output logic        pre_bit,
	output logic [15:0] status
);
	initial begin
		sclk = 1'b0;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
	end
	// Leading bits beyond 16 are a filler pattern, as a chain would pass
	task automatic frame(input logic [15:0] word, input int n);
		logic [31:0] v;
		v = {16'h5a3c, word};
		chip_select_n = 1'b0;
		#100;
		pre_bit = serial_out;
		for (int i = 0; i < n; i++) begin
			serial_in = v[n-1-i];
			#31;
			sclk = 1'b1;
			#62;
			if (i < 16)
				status = {status[14:0], serial_out};
			sclk = 1'b0;
			#32;
		end
		serial_in = 1'b0;
		#100;
		chip_select_n = 1'b1;
		#(word[15] ? 150000 : 5000);
	endtask
endmodule

/* File: sim/halfbridge_spi_command_port_asserts.sv */
// Pin-level checks of the half-bridge command port
`timescale 1ns/10ps
module halfbridge_spi_command_port_asserts
	import hb_pkg::*;
#(
	parameter int N_BRIDGES = BRIDGES
) (
	// Clocks and reset
	input wire logic                 clk,
	input wire logic                 sclk,
	input wire logic                 reset,
	// Serial, enable and supply fault pins
	input wire logic                 chip_enable,
	input wire logic                 chip_select_n,
	input wire logic                 serial_in,
	input wire logic                 serial_out,
	input wire logic                 serial_out_oe,
	input wire logic                 supply_fault,
	// Driver control
	input wire logic [N_BRIDGES-1:0] bridge_output_state,
	input wire logic [N_BRIDGES-1:0] bridge_config_state,
	input wire logic [N_BRIDGES-1:0] underload_shutdown_enable,
	input wire logic                 overvoltage_lockout_enable,
	input wire logic                 sleep
);
	logic [4:0]  edge_cnt;
	logic [16:0] in_hist;
	// Saturates so long chains never wrap back to the pre-bit phase
	always_ff @(posedge sclk or posedge reset or posedge chip_select_n) begin
		if (reset || chip_select_n)
			edge_cnt <= 5'h00;
		else if (edge_cnt != 5'h1f)
			edge_cnt <= edge_cnt + 5'h01;
	end
	always_ff @(posedge sclk) begin
		in_hist <= {in_hist[15:0], serial_in};
	end
	property p_oe_off;
		@(posedge clk) disable iff (reset) (chip_select_n || !chip_enable) |-> !serial_out_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("serial out driven outside frame");
	property p_oe_on;
		@(posedge clk) disable iff (reset) (!chip_select_n && chip_enable) |-> serial_out_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("serial out not driven in frame");
	property p_cfg_forced;
		@(posedge clk) disable iff (reset) (bridge_config_state & ~bridge_output_state) == '0;
	endproperty
	a_cfg_forced: assert property (p_cfg_forced) else $error("config set on idle bridge");
	property p_sleep_clear;
		@(posedge clk) disable iff (reset) !chip_enable [*5] |-> sleep
			&& bridge_output_state == '0 && underload_shutdown_enable == '0
			&& !overvoltage_lockout_enable;
	endproperty
	a_sleep_clear: assert property (p_sleep_clear) else $error("state kept while disabled");
	property p_frame_hold;
		@(posedge clk) disable iff (reset) (!chip_select_n && chip_enable) [*8]
			|-> $stable(underload_shutdown_enable) && $stable(overvoltage_lockout_enable);
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("command changed in frame");
	property p_lockout;
		@(posedge clk) disable iff (reset) (overvoltage_lockout_enable && supply_fault) [*6]
			|-> bridge_output_state == '0;
	endproperty
	a_lockout: assert property (p_lockout) else $error("bridge on under lockout");
	property p_chain;
		@(negedge sclk) disable iff (reset) (!chip_select_n && edge_cnt > 5'h10)
			|-> serial_out == in_hist[16];
	endproperty
	a_chain: assert property (p_chain) else $error("chained data not passed on");
	property p_pre_hold;
		@(posedge clk) disable iff (reset) (!chip_select_n && !$past(chip_select_n)
			&& edge_cnt == 5'h00) |-> $stable(serial_out);
	endproperty
	a_pre_hold: assert property (p_pre_hold) else $error("pre-bit moved before clock");
	c_commit: cover property (@(posedge clk) disable iff (reset) $rose(chip_select_n));
	c_lock: cover property (@(posedge clk) disable iff (reset)
		supply_fault && overvoltage_lockout_enable);
	c_chain: cover property (@(negedge sclk) disable iff (reset) edge_cnt == 5'h18);
endmodule
bind halfbridge_spi_command_port halfbridge_spi_command_port_asserts #(.N_BRIDGES(N_BRIDGES))
	chk (.*);

/* File: sim/halfbridge_spi_command_port_bench.sv */
// Self-checking bench for the half-bridge command port
`timescale 1ns/10ps
module halfbridge_spi_command_port_bench;
	import hb_pkg::*;
	logic        clk;
	logic        reset;
	logic        chip_enable;
	logic        sclk;
	logic        chip_select_n;
	logic        serial_in;
	logic        serial_out;
	logic        serial_out_oe;
	logic        so_pin;
	logic [7:0]  overcurrent_fault;
	logic [7:0]  underload_fault;
	logic        supply_fault;
	logic        thermal_warning;
	logic        thermal_shutdown;
	logic [7:0]  bridge_output_state;
	logic [7:0]  bridge_config_state;
	logic [7:0]  underload_shutdown_enable;
	logic        overvoltage_lockout_enable;
	logic        sleep;
	logic        pre_bit;
	logic [15:0] status;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cycles = 0;
	// Released line floats; never let it look like the last bit
	assign so_pin = serial_out_oe ? serial_out : ~serial_out;
	halfbridge_spi_command_port dut (.*);
	hb_host host (.sclk(sclk), .chip_select_n(chip_select_n), .serial_in(serial_in),
		.serial_out(so_pin), .pre_bit(pre_bit), .status(status));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			error_cnt++;
			test_done();
		end
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", name, exp, got);
		end
	endtask
	task automatic drive(input logic [7:0] st, input logic [7:0] cf);
		chk("state", {8'h00, st}, {8'h00, bridge_output_state});
		chk("config", {8'h00, cf}, {8'h00, bridge_config_state});
	endtask
	task automatic send(input logic [15:0] w, input int n, input logic pb, input logic [15:0] sw);
		host.frame(w, n);
		chk("pre", {15'h0000, pb}, {15'h0000, pre_bit});
		chk("status", sw, status);
	endtask
	task test_done;
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		chip_enable = 1'b0;
		overcurrent_fault = 8'h00;
		underload_fault = 8'h00;
		supply_fault = 1'b0;
		thermal_warning = 1'b0;
		thermal_shutdown = 1'b0;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		chk("sleep", 16'h0001, {15'h0000, sleep});
		chip_enable = 1'b1;
		repeat (8) @(negedge clk);
		chk("sleep", 16'h0000, {15'h0000, sleep});
		drive(8'h00, 8'h00);
		send(16'h16cc, 16, 1'b0, 16'h0000);
		drive(8'h2d, 8'h24);
		thermal_warning = 1'b1;
		repeat (4) @(negedge clk);
		send(16'h75ab, 16, 1'b0, 16'h16c9);
		drive(8'hed, 8'h64);
		chk("uld_en", 16'h00c0, {8'h00, underload_shutdown_enable});
		chk("overvoltage_lockout_enable", 16'h0001, {15'h0000, overvoltage_lockout_enable});
		host.frame(16'h6180, 0);
		host.frame(16'h6180, 15);
		host.frame(16'h6180, 20);
		drive(8'hed, 8'h64);
		send(16'h6180, 24, 1'b0, 16'h0183);
		drive(8'hed, 8'h24);
		overcurrent_fault = 8'h40;
		underload_fault = 8'h81;
		repeat (8) @(negedge clk);
		overcurrent_fault = 8'h00;
		underload_fault = 8'h00;
		repeat (8) @(negedge clk);
		drive(8'h2d, 8'h24);
		// Thermal shutdown latch takes every bridge off
		thermal_shutdown = 1'b1;
		repeat (8) @(negedge clk);
		thermal_shutdown = 1'b0;
		drive(8'h00, 8'h00);
		send(16'h6180, 16, 1'b1, 16'ha001);
		drive(8'h00, 8'h00);
		send(16'he181, 16, 1'b1, 16'ha001);
		drive(8'hed, 8'h24);
		supply_fault = 1'b1;
		repeat (8) @(negedge clk);
		drive(8'h00, 8'h00);
		supply_fault = 1'b0;
		repeat (8) @(negedge clk);
		send(16'h6180, 16, 1'b0, 16'h0181);
		drive(8'hed, 8'h24);
		chip_enable = 1'b0;
		repeat (8) @(negedge clk);
		drive(8'h00, 8'h00);
		chk("sleep", 16'h0001, {15'h0000, sleep});
		host.frame(16'h75ab, 16);
		chip_enable = 1'b1;
		repeat (8) @(negedge clk);
		drive(8'h00, 8'h00);
		send(16'h16cc, 16, 1'b0, 16'h0001);
		drive(8'h2d, 8'h24);
		test_done();
	end
endmodule
